// >>> rtl/pvp_pkg.sv
// Register map, field positions and states of the parallel video port
package pvp_pkg;
  localparam int AW = 8;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_DLY  = 8'h04;
  localparam logic [AW-1:0] A_PER  = 8'h08;
  localparam logic [AW-1:0] A_CNT  = 8'h0c;
  localparam logic [AW-1:0] A_STAT = 8'h10;
  localparam logic [AW-1:0] A_RXD  = 8'h14;
  localparam logic [AW-1:0] A_TXD  = 8'h18;
  // Control fields
  localparam int C_EN  = 0;
  localparam int C_XT  = 1;
  localparam int C_FSI = 3;
  localparam int C_LVL = 4;
  localparam int C_FLT = 6;
  localparam int C_E10 = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_01ff;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0010;
  localparam logic [31:0] DLY_RST   = 32'h0000_0000;
  localparam logic [31:0] PER_RST   = 32'h0001_00ff;
  localparam logic [31:0] CNT_RST   = 32'h0000_0010;
  localparam int PER_LINES = 16;
  // Status fields
  localparam int S_RXV  = 0;
  localparam int S_TXR  = 1;
  localparam int S_OVF  = 2;
  localparam int S_UNF  = 3;
  localparam int S_BUSY = 4;
  // Embedded code bytes, compared on the upper eight bits of an element
  localparam logic [7:0] K_FF = 8'hff;
  localparam logic [7:0] K_00 = 8'h00;
  localparam int XY_V = 5;
  localparam int XY_H = 4;
  localparam int PIPE = 4;
  typedef enum logic [1:0] {
    XT_GRX = 2'h0, XT_GTX = 2'h1, XT_VRX = 2'h2, XT_VTX = 2'h3
  } pvp_xfer_t;
  typedef enum logic [1:0] {
    FL_ACT = 2'h0, FL_VBI = 2'h1, FL_ALL = 2'h2
  } pvp_flt_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_DLY = 3'b010, ST_XFER = 3'b100
  } pvp_st_t;
endpackage

// >>> rtl/pvp_port.sv
// Parallel video port: APB registers, port clock capture and launch
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - One input port clock, up to three frame syncs, up to sixteen data pins.
// - Video receive parses 8-bit or 10-bit elements.
// - Video receive decodes embedded preamble and sync codes on chip.
// - Active-only drops blanking between EAV and SAV and vertical blanking.
// - Active-only never forwards the control code bytes.
// - Blanking-only forwards vertical blanking lines, codes included.
// - Entire-field forwards every element of the stream.
// - Sync-less transmit streams prepared words out verbatim.
// - General-purpose modes move up to sixteen bits per port clock.
// - Receive and transmit with internally generated frame syncs.
// - External frame syncs come from far side; transfers align to them.
// - One, two or three frame sync levels are supported.
// - Programmable port clock delay from frame sync to first data.
module pvp_port #(
  parameter int DW = 16,
  parameter int CW = 16
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [pvp_pkg::AW-1:0] paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic                       pready_o,
  output logic [31:0]                prdata_o,
  output logic                       pslverr_o,
  input  wire logic                  port_input_clock_i,
  input  wire logic [2:0]            fs_in_i,
  output logic [2:0]                 fs_out_o,
  output logic [2:0]                 fs_oe_n_o,
  input  wire logic [DW-1:0]         data_in_i,
  output logic [DW-1:0]              data_out_o,
  output logic                       data_oe_n_o
);
  // System side registers
  logic [31:0]         ctrl;
  logic [31:0]         dly_r;
  logic [31:0]         per_r;
  logic [31:0]         cnt_r;
  logic                perr;
  logic [DW-1:0]       rx_word;
  logic                rx_v;
  logic                ovf;
  logic [DW-1:0]       tx_word;
  logic                tx_tgl;
  logic [2:0]          rxt_s;
  logic [1:0]          ack_s;
  logic [1:0]          unf_s;
  logic [1:0]          busy_s;
  logic [31:0]         stat;
  // Port side registers
  logic [1:0]          prs;
  logic [1:0]          ens;
  logic [2:0]          txt_s;
  logic [DW-1:0]       rx_hold;
  logic                rx_tgl;
  logic [DW-1:0]       tx_hold;
  logic                tx_full;
  logic                tx_ack;
  logic                unf_p;
  logic                busy_p;
  pvp_pkg::pvp_st_t    st;
  logic [CW-1:0]       dcnt;
  logic [CW-1:0]       scnt;
  logic [CW-1:0]       gcnt;
  logic [CW-1:0]       lcnt;
  logic                fld;
  logic                fs1_q;
  logic [DW-1:0]       pd [pvp_pkg::PIPE];
  logic [pvp_pkg::PIPE-1:0] pc;
  logic                vb;
  logic                hb;

  // Decoded fields; config is only changed while the port is disabled
  logic                en;
  pvp_pkg::pvp_xfer_t  xt;
  pvp_pkg::pvp_flt_t   flt;
  logic [1:0]          lvl;
  logic                fsi;
  logic                e10;
  logic                gp;
  logic                txm;
  logic                vrx;
  assign en  = ctrl[pvp_pkg::C_EN];
  assign xt  = pvp_pkg::pvp_xfer_t'(ctrl[pvp_pkg::C_XT +: 2]);
  assign flt = pvp_pkg::pvp_flt_t'(ctrl[pvp_pkg::C_FLT +: 2]);
  assign lvl = ctrl[pvp_pkg::C_LVL +: 2];
  assign fsi = ctrl[pvp_pkg::C_FSI];
  assign e10 = ctrl[pvp_pkg::C_E10];
  assign gp  = (xt == pvp_pkg::XT_GRX) || (xt == pvp_pkg::XT_GTX);
  assign txm = (xt == pvp_pkg::XT_GTX) || (xt == pvp_pkg::XT_VTX);
  assign vrx = (xt == pvp_pkg::XT_VRX);

  // APB slave, zero wait states; read data is latched in the setup phase
  logic setup;
  logic wr_ok;
  logic pop;
  logic tx_rdy;
  logic rx_arr;
  assign setup     = psel_i & ~penable_i;
  assign wr_ok     = psel_i & penable_i & pwrite_i & ~perr;
  assign pop       = psel_i & penable_i & ~pwrite_i & ~perr
                     & (paddr_i == pvp_pkg::A_RXD);
  assign pready_o  = 1'b1;
  assign pslverr_o = perr & psel_i & penable_i;
  assign tx_rdy    = (ack_s[1] == tx_tgl);
  assign rx_arr    = rxt_s[2] ^ rxt_s[1];

  always_comb begin
    stat = '0;
    stat[pvp_pkg::S_RXV]  = rx_v;
    stat[pvp_pkg::S_TXR]  = tx_rdy;
    stat[pvp_pkg::S_OVF]  = ovf;
    stat[pvp_pkg::S_UNF]  = unf_s[1];
    stat[pvp_pkg::S_BUSY] = busy_s[1];
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prdata_o <= '0;
      perr     <= 1'b0;
    end else if (setup) begin
      prdata_o <= '0;
      perr     <= 1'b0;
      if (paddr_i == pvp_pkg::A_CTRL) begin
        prdata_o <= ctrl;
      end else if (paddr_i == pvp_pkg::A_DLY) begin
        prdata_o <= dly_r;
        perr     <= pwrite_i & en;
      end else if (paddr_i == pvp_pkg::A_PER) begin
        prdata_o <= per_r;
        perr     <= pwrite_i & en;
      end else if (paddr_i == pvp_pkg::A_CNT) begin
        prdata_o <= cnt_r;
        perr     <= pwrite_i & en;
      end else if (paddr_i == pvp_pkg::A_STAT) begin
        prdata_o <= stat;
      end else if (paddr_i == pvp_pkg::A_RXD) begin
        prdata_o <= 32'(rx_word);
        perr     <= pwrite_i;
      end else if (paddr_i == pvp_pkg::A_TXD) begin
        // A word still in flight refuses the next one
        perr     <= ~pwrite_i | ~tx_rdy;
      end else begin
        perr     <= 1'b1;
      end
    end
  end

  // Configuration; while enabled only the enable bit may change
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl  <= pvp_pkg::CTRL_RST;
      dly_r <= pvp_pkg::DLY_RST;
      per_r <= pvp_pkg::PER_RST;
      cnt_r <= pvp_pkg::CNT_RST;
    end else if (wr_ok) begin
      if (paddr_i == pvp_pkg::A_CTRL) begin
        if (en) begin
          ctrl[pvp_pkg::C_EN] <= pwdata_i[pvp_pkg::C_EN];
        end else begin
          ctrl <= pwdata_i & pvp_pkg::CTRL_MASK;
        end
      end else if (paddr_i == pvp_pkg::A_DLY) begin
        dly_r <= pwdata_i;
      end else if (paddr_i == pvp_pkg::A_PER) begin
        per_r <= pwdata_i;
      end else if (paddr_i == pvp_pkg::A_CNT) begin
        cnt_r <= pwdata_i;
      end
    end
  end

  // Receive words arrive by toggle; the arrival wins over a pop
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rxt_s   <= '0;
      rx_v    <= 1'b0;
      ovf     <= 1'b0;
      rx_word <= '0;
    end else begin
      rxt_s <= {rxt_s[1:0], rx_tgl};
      if (rx_arr) begin
        rx_word <= rx_hold;
        rx_v    <= 1'b1;
      end else if (pop) begin
        rx_v    <= 1'b0;
      end
      if (rx_arr & rx_v & ~pop) begin
        ovf <= 1'b1;
      end else if (wr_ok && paddr_i == pvp_pkg::A_STAT
                   && pwdata_i[pvp_pkg::S_OVF]) begin
        ovf <= 1'b0;
      end
    end
  end

  // Transmit words leave by toggle and return an acknowledge
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_tgl  <= 1'b0;
      tx_word <= '0;
      ack_s   <= '0;
      unf_s   <= '0;
      busy_s  <= '0;
    end else begin
      ack_s  <= {ack_s[0], tx_ack};
      unf_s  <= {unf_s[0], unf_p};
      busy_s <= {busy_s[0], busy_p};
      if (wr_ok && paddr_i == pvp_pkg::A_TXD) begin
        tx_word <= pwdata_i[DW-1:0];
        tx_tgl  <= ~tx_tgl;
      end
    end
  end

  // Port clock domain: reset and enable arrive through two flops
  logic pclr;
  logic tx_arr;
  assign pclr   = prs[1] | ~ens[1];
  assign tx_arr = txt_s[2] ^ txt_s[1];

  always_ff @(posedge port_input_clock_i) begin
    prs   <= {prs[0], srst_i};
    ens   <= {ens[0], en};
    txt_s <= {txt_s[1:0], tx_tgl};
    busy_p <= (st != pvp_pkg::ST_IDLE); // Flopped so no decode glitch crosses
  end

  // Internal sync generator: line pulse, frame pulse, field level
  logic gline;
  logic lend;
  assign gline = fsi & gp & (gcnt == '0);
  assign lend  = (gcnt == per_r[CW-1:0]);
  always_ff @(posedge port_input_clock_i) begin
    if (pclr | ~fsi) begin
      gcnt     <= '0;
      lcnt     <= '0;
      fld      <= 1'b0;
      fs_out_o <= '0;
    end else begin
      gcnt <= lend ? '0 : gcnt + 1'b1;
      if (lend) begin
        if (lcnt == per_r[pvp_pkg::PER_LINES +: CW]) begin
          lcnt <= '0;
          fld  <= ~fld;
        end else begin
          lcnt <= lcnt + 1'b1;
        end
      end
      fs_out_o[0] <= gline;
      fs_out_o[1] <= gline & (lcnt == '0);
      fs_out_o[2] <= fld;
    end
  end

  // Drive only as many sync pins as levels in use
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      fs_oe_n_o[i] = ~(fsi & gp & ens[1] & ((i == 0) || (i < int'(lvl))));
    end
  end

  // Frame start: leading sync edge qualified by higher levels
  logic [2:0] fsv;
  logic fs_go;
  logic go;
  assign fsv   = fsi ? fs_out_o : fs_in_i;
  assign fs_go = fsv[0] & ~fs1_q & ((lvl < 2'h2) | fsv[1])
                 & ((lvl < 2'h3) | fsv[2]);
  // Video receive never looks at the sync pins
  assign go    = gp ? fs_go : (xt == pvp_pkg::XT_VTX);

  always_ff @(posedge port_input_clock_i) begin
    if (pclr) begin
      fs1_q <= 1'b0;
    end else begin
      fs1_q <= fsv[0];
    end
  end

  // Delay then transfer; sync-less transmit never leaves the transfer
  always_ff @(posedge port_input_clock_i) begin
    if (pclr) begin
      st   <= pvp_pkg::ST_IDLE;
      dcnt <= '0;
      scnt <= '0;
    end else begin
      case (st)
        pvp_pkg::ST_IDLE: begin
          scnt <= '0;
          if (go && dly_r[CW-1:0] == '0) begin
            st <= pvp_pkg::ST_XFER;
          end else if (go) begin
            st   <= pvp_pkg::ST_DLY;
            dcnt <= dly_r[CW-1:0] - 1'b1;
          end
        end
        pvp_pkg::ST_DLY: begin
          if (dcnt == '0) begin
            st <= pvp_pkg::ST_XFER;
          end else begin
            dcnt <= dcnt - 1'b1;
          end
        end
        pvp_pkg::ST_XFER: begin
          scnt <= scnt + 1'b1;
          if (xt != pvp_pkg::XT_VTX && scnt == cnt_r[CW-1:0] - 1'b1) begin
            st <= pvp_pkg::ST_IDLE;
          end
        end
        default: st <= pvp_pkg::ST_IDLE;
      endcase
    end
  end

  // Embedded code parser over a four element pipe
  function automatic logic [7:0] top8(input logic [DW-1:0] d, input logic w10);
    top8 = w10 ? d[9:2] : d[7:0];
  endfunction
  logic [7:0] el;
  logic det;
  logic emit;
  assign el  = top8(data_in_i, e10);
  assign det = vrx && top8(pd[2], e10) == pvp_pkg::K_FF
               && top8(pd[1], e10) == pvp_pkg::K_00
               && top8(pd[0], e10) == pvp_pkg::K_00;

  always_ff @(posedge port_input_clock_i) begin
    if (pclr | ~vrx) begin
      for (int i = 0; i < pvp_pkg::PIPE; i++) begin
        pd[i] <= '0;
      end
      pc <= '1;
      vb <= 1'b1;
      hb <= 1'b1;
    end else begin
      pd[0] <= data_in_i;
      for (int i = 1; i < pvp_pkg::PIPE; i++) begin
        pd[i] <= pd[i-1];
      end
      // The three preamble bytes and the code word are all marked
      pc <= det ? '1 : {pc[pvp_pkg::PIPE-2:0], 1'b0};
      if (det) begin
        vb <= el[pvp_pkg::XY_V];
        hb <= el[pvp_pkg::XY_H];
      end
    end
  end

  always_comb begin
    case (flt)
      pvp_pkg::FL_ACT: emit = vrx & ~pc[3] & ~hb & ~vb;
      pvp_pkg::FL_VBI: emit = vrx & vb;
      default:         emit = vrx;
    endcase
  end

  // Capture; a hold word must be taken by the system side within one port period
  always_ff @(posedge port_input_clock_i) begin
    if (prs[1]) begin
      rx_hold <= '0;
      rx_tgl  <= 1'b0;
    end else if (~pclr) begin
      if (xt == pvp_pkg::XT_GRX && st == pvp_pkg::ST_XFER) begin
        rx_hold <= data_in_i;
        rx_tgl  <= ~rx_tgl;
      end else if (emit) begin
        rx_hold <= pd[3];
        rx_tgl  <= ~rx_tgl;
      end
    end
  end

  // Launch; without a fresh word the last one repeats and underrun is flagged
  logic launch;
  assign launch      = txm & (st == pvp_pkg::ST_XFER);
  assign data_oe_n_o = ~(txm & ens[1]);
  always_ff @(posedge port_input_clock_i) begin
    if (prs[1]) begin
      tx_hold    <= '0;
      tx_full    <= 1'b0;
      tx_ack     <= 1'b0;
      unf_p      <= 1'b0;
      data_out_o <= '0;
    end else begin
      if (tx_arr) begin
        tx_hold <= tx_word;
        tx_full <= 1'b1;
      end else if (launch & tx_full) begin
        tx_full <= 1'b0;
      end
      if (launch & tx_full) begin
        data_out_o <= tx_hold;
        tx_ack     <= ~tx_ack;
      end
      if (~ens[1]) begin
        unf_p <= 1'b0;
      end else if (launch & ~tx_full) begin
        unf_p <= 1'b1;
      end
    end
  end

  // Checks
  property p_rx_arrive;
    @(posedge core_clk_i) disable iff (srst_i)
    rx_arr |=> rx_v && rx_word == $past(rx_hold);
  endproperty
  a_rx_arrive: assert property (p_rx_arrive) else $error("rx word lost");

  property p_tx_busy;
    @(posedge core_clk_i) disable iff (srst_i)
    (wr_ok && paddr_i == pvp_pkg::A_TXD) |=> !tx_rdy ##1 !tx_rdy;
  endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("tx ready too early");

  property p_no_delay;
    @(posedge port_input_clock_i) disable iff (pclr)
    (st == pvp_pkg::ST_IDLE && go && dly_r[CW-1:0] == '0) |=> st == pvp_pkg::ST_XFER;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("zero delay not honoured");

  property p_delay;
    @(posedge port_input_clock_i) disable iff (pclr)
    (st == pvp_pkg::ST_IDLE && go && dly_r[CW-1:0] != '0) |=>
      st == pvp_pkg::ST_DLY && dcnt == $past(dly_r[CW-1:0]) - 1'b1;
  endproperty
  a_delay: assert property (p_delay) else $error("delay count wrong");

  property p_det;
    @(posedge port_input_clock_i) disable iff (pclr)
    det |=> pc == '1 ##1 pc[3];
  endproperty
  a_det: assert property (p_det) else $error("code bytes not marked");

  property p_act;
    @(posedge port_input_clock_i) disable iff (pclr)
    (vrx && flt == pvp_pkg::FL_ACT && rx_tgl != $past(rx_tgl)) |-> !$past(pc[3]);
  endproperty
  a_act: assert property (p_act) else $error("code byte forwarded");

  property p_vbi;
    @(posedge port_input_clock_i) disable iff (pclr)
    (vrx && flt == pvp_pkg::FL_VBI && !vb) |=> rx_tgl == $past(rx_tgl);
  endproperty
  a_vbi: assert property (p_vbi) else $error("non blanking forwarded");

  property p_all;
    @(posedge port_input_clock_i) disable iff (pclr)
    (vrx && flt == pvp_pkg::FL_ALL) |=> rx_tgl != $past(rx_tgl);
  endproperty
  a_all: assert property (p_all) else $error("element dropped");

  property p_gen;
    @(posedge port_input_clock_i) disable iff (pclr)
    (fsi && gp && gcnt == '0) |=> fs_out_o[0] ##1 !fs_out_o[0];
  endproperty
  a_gen: assert property (p_gen) else $error("internal sync missing");

  c_frame: cover property (@(posedge port_input_clock_i) disable iff (pclr)
    st == pvp_pkg::ST_XFER ##1 st == pvp_pkg::ST_IDLE);
  c_code: cover property (@(posedge port_input_clock_i) disable iff (pclr) det && !hb);
  c_unf: cover property (@(posedge port_input_clock_i) disable iff (pclr)
    launch && !tx_full);
endmodule
`default_nettype wire

// >>> tb/pvp_far_end.sv
// Far-side model of the port: port clock, frame syncs and data source
`timescale 1ns/1ns
`default_nettype none
module pvp_far_end (
  output logic             port_clk_o,
  output logic [2:0]       fs_pin_o,
  output logic [15:0]      data_pin_o,
  input  wire logic [2:0]  fs_out_i,
  input  wire logic [2:0]  fs_oe_n_i,
  input  wire logic [15:0] data_out_i,
  input  wire logic        data_oe_n_i
);
  logic [2:0]  fs_drv;
  logic [15:0] dat_drv;
  // Pixel clock runs free; odd start keeps it unrelated to the core clock
  initial begin
    port_clk_o = 1'b0;
    #13;
    forever #40 port_clk_o = ~port_clk_o;
  end
  initial begin
    fs_drv = 3'h0;
    dat_drv = 16'h0000;
  end
  // Each pin shows its driver; the device wins while its enable is low
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      fs_pin_o[i] = fs_oe_n_i[i] ? fs_drv[i] : fs_out_i[i];
    end
    data_pin_o = data_oe_n_i ? dat_drv : data_out_i;
  end
  // Syncs and data change just after a port clock edge
  task automatic put(input logic [2:0] f, input logic [15:0] d);
    @(posedge port_clk_o);
    fs_drv <= f;
    dat_drv <= d;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the parallel video port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] dly;
    logic [2:0]  fs;
    logic        v;
    logic        rxv;
    logic        ovf;
    logic [15:0] d;
  } pvp_row_t;
  logic        core_clk, srst, psel, penable, pwrite, pready, pslverr, pclk, data_oe_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0]  fs_pin, fs_out, fs_oe_n;
  logic [15:0] data_pin, data_out;
  logic        rerr;
  int          errors, checked;
  pvp_row_t    rows [12] = '{
    '{32'h11, 16'h0, 3'h1, 1'b0, 1'b1, 1'b0, 16'h0101},
    '{32'h11, 16'h3, 3'h1, 1'b0, 1'b1, 1'b0, 16'h0104},
    '{32'h21, 16'h0, 3'h3, 1'b0, 1'b1, 1'b0, 16'h0101},
    '{32'h21, 16'h0, 3'h1, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{32'h31, 16'h0, 3'h7, 1'b0, 1'b1, 1'b0, 16'h0101},
    '{32'h31, 16'h0, 3'h3, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{32'h05, 16'h0, 3'h0, 1'b0, 1'b1, 1'b0, 16'h005a},
    '{32'h05, 16'h0, 3'h0, 1'b1, 1'b0, 1'b0, 16'h0000},
    '{32'h45, 16'h0, 3'h0, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{32'h45, 16'h0, 3'h0, 1'b1, 1'b1, 1'b1, 16'h0000},
    '{32'h85, 16'h0, 3'h0, 1'b0, 1'b1, 1'b1, 16'h0000},
    '{32'h105, 16'h0, 3'h0, 1'b0, 1'b1, 1'b0, 16'h0168}};
  logic [8:0]  bad [5] = '{9'h104, 9'h114, 9'h018, 9'h01c, 9'h140};
  pvp_port #(.DW(16), .CW(16)) pvp_port_inst (
    .core_clk_i(core_clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .port_input_clock_i(pclk),
    .fs_in_i(fs_pin), .fs_out_o(fs_out), .fs_oe_n_o(fs_oe_n), .data_in_i(data_pin),
    .data_out_o(data_out), .data_oe_n_o(data_oe_n));
  pvp_far_end pvp_far_end_inst (
    .port_clk_o(pclk), .fs_pin_o(fs_pin), .data_pin_o(data_pin), .fs_out_i(fs_out),
    .fs_oe_n_i(fs_oe_n), .data_out_i(data_out), .data_oe_n_i(data_oe_n));
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Zero-wait slave, but the master still waits on pready like any other
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pe(input int sh, input logic [7:0] b);
    pvp_far_end_inst.put(3'h0, 16'(b) << sh);
  endtask
  task automatic code(input int sh, input logic [7:0] xy);
    pe(sh, 8'hff);
    pe(sh, 8'h00);
    pe(sh, 8'h00);
    pe(sh, xy);
  endtask
  // Leading blanking code, flush, then one active element between codes
  task automatic vid(input int sh, input logic v);
    code(sh, {2'b10, v, 5'h10});
    pe(sh, 8'h10);
    repeat (8) @(posedge pclk);
    apb(1'b0, pvp_pkg::A_RXD, 32'h0);
    apb(1'b1, pvp_pkg::A_STAT, 32'h4);
    code(sh, {2'b10, v, 5'h00});
    pe(sh, 8'h5a);
    code(sh, {2'b10, v, 5'h10});
    pe(sh, 8'h10);
    repeat (8) @(posedge pclk);
  endtask
  task automatic frame(input logic [2:0] f, input int n);
    for (int k = 0; k < n; k++) pvp_far_end_inst.put(f, 16'h0100 + 16'(k));
    pvp_far_end_inst.put(3'h0, 16'hfeff);
  endtask
  task automatic rstchk();
    apb(1'b0, pvp_pkg::A_CTRL, 32'h0);
    chk(rdat, pvp_pkg::CTRL_RST);
    apb(1'b0, pvp_pkg::A_DLY, 32'h0);
    chk(rdat, pvp_pkg::DLY_RST);
    apb(1'b0, pvp_pkg::A_PER, 32'h0);
    chk(rdat, pvp_pkg::PER_RST);
    apb(1'b0, pvp_pkg::A_CNT, 32'h0);
    chk(rdat, pvp_pkg::CNT_RST);
    chk({fs_oe_n, data_oe_n}, 4'hf);
  endtask
  task automatic ctl(input logic [31:0] c);
    apb(1'b1, pvp_pkg::A_CTRL, 32'h0);
    apb(1'b1, pvp_pkg::A_CTRL, c);
  endtask
  initial begin
    #500000;
    errors++;
    summarize();
  end
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata, errors, checked} = '0;
    srst = 1'b1;
    // Port side resyncs reset, so hold it past three port clock edges
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    rstchk();
    apb(1'b1, pvp_pkg::A_CNT, 32'h1);
    for (int r = 0; r < 12; r++) begin
      apb(1'b1, pvp_pkg::A_CTRL, 32'h0);
      apb(1'b1, pvp_pkg::A_DLY, {16'h0000, rows[r].dly});
      apb(1'b0, pvp_pkg::A_RXD, 32'h0);
      apb(1'b1, pvp_pkg::A_STAT, 32'h4);
      apb(1'b1, pvp_pkg::A_CTRL, rows[r].ctrl);
      // Let the enable cross to the port side before the far side starts
      repeat (4) @(posedge pclk);
      if (rows[r].ctrl[2:1] == 2'h2) vid(rows[r].ctrl[8] ? 2 : 0, rows[r].v);
      else frame(rows[r].fs, 6);
      repeat (20) @(posedge core_clk);
      apb(1'b0, pvp_pkg::A_STAT, 32'h0);
      chk(rdat[1:0], {1'b1, rows[r].rxv});
      chk(rdat[2], rows[r].ovf);
      apb(1'b0, pvp_pkg::A_RXD, 32'h0);
      if (rows[r].rxv && !rows[r].ovf) chk(rdat[15:0], rows[r].d);
      $display("test row %0d done", r);
    end
    // Setup registers are locked while enabled, so stop the port first
    apb(1'b1, pvp_pkg::A_CTRL, 32'h0);
    apb(1'b1, pvp_pkg::A_PER, 32'hf);
    apb(1'b1, pvp_pkg::A_CTRL, 32'h1b);
    apb(1'b0, pvp_pkg::A_STAT, 32'h0);
    chk(rdat[1], 1'b1);
    apb(1'b1, pvp_pkg::A_TXD, 32'ha5c3);
    chk(rerr, 1'b0);
    apb(1'b1, pvp_pkg::A_TXD, 32'h5a5a);
    chk(rerr, 1'b1);
    repeat (40) @(posedge pclk);
    chk({fs_oe_n, data_oe_n, data_out}, {4'hc, 16'ha5c3});
    apb(1'b0, pvp_pkg::A_STAT, 32'h0);
    chk(rdat[3], 1'b1);
    $display("test internal sync transmit done");
    ctl(32'h13);
    apb(1'b1, pvp_pkg::A_TXD, 32'h3c5a);
    repeat (8) @(posedge pclk);
    frame(3'h1, 4);
    repeat (8) @(posedge pclk);
    chk({fs_oe_n, data_out}, {3'h7, 16'h3c5a});
    ctl(32'h17);
    apb(1'b1, pvp_pkg::A_TXD, 32'h0ff0);
    repeat (8) @(posedge pclk);
    chk({fs_oe_n, data_oe_n, data_out}, {4'he, 16'h0ff0});
    apb(1'b0, pvp_pkg::A_STAT, 32'h0);
    chk(rdat[4], 1'b1);
    $display("test external and sync-less transmit done");
    ctl(32'h19);
    apb(1'b0, pvp_pkg::A_RXD, 32'h0);
    pvp_far_end_inst.put(3'h0, 16'h1234);
    repeat (40) @(posedge pclk);
    apb(1'b0, pvp_pkg::A_RXD, 32'h0);
    chk({fs_oe_n, rdat[15:0]}, {3'h6, 16'h1234});
    // Refused while enabled: config, read-only, write-only and unmapped
    for (int i = 0; i < 5; i++) begin
      apb(bad[i][8], bad[i][7:0], 32'hffff);
      chk(rerr, 1'b1);
    end
    apb(1'b1, pvp_pkg::A_CTRL, 32'h0);
    apb(1'b0, pvp_pkg::A_DLY, 32'h0);
    chk(rdat, 32'h0);
    $display("test internal sync receive done");
    apb(1'b1, pvp_pkg::A_CTRL, 32'h19);
    srst <= 1'b1;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    rstchk();
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
